//--- hdl/urc_ir_demod.sv
// infrared pulse detector with its clock divider
// assumes line_in is synchronised
`timescale 1ns/1ps
`default_nettype none
`include "urc_regs.svh"

module urc_ir_demod
    import urc_pkg::*;
#(
    parameter int DIV_W = 7
) (
    input  wire logic       sys_clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       enable_in,
    input  wire logic       line_in,
    input  wire logic [2:0] div_sel_in,
    output logic            pulse_out
);

    logic [DIV_W-1:0] div_cnt_reg;
    logic [DIV_W-1:0] div_cnt_next;
    logic [1:0]       low_cnt_reg;
    logic [1:0]       low_cnt_next;
    logic             pulse_reg;
    logic             pulse_next;
    logic [DIV_W-1:0] div_mask;
    logic             tick;

    // ------------------------------------------------------------------
    // detection clock enable
    // ------------------------------------------------------------------
    always_comb begin
        div_mask = DIV_W'((8'h01 << div_sel_in) - 8'h01);
        tick     = ((div_cnt_reg & div_mask) == div_mask);
        div_cnt_next = enable_in ? DIV_W'(div_cnt_reg + 1'b1) : '0;
    end

    // ------------------------------------------------------------------
    // low width filter
    // ------------------------------------------------------------------
    // one pulse per low run; a short glitch never reaches the limit
    always_comb begin
        low_cnt_next = low_cnt_reg;
        pulse_next   = 1'b0;
        if (!enable_in) begin
            low_cnt_next = 2'h0;
        end else if (tick) begin
            if (line_in) begin
                low_cnt_next = 2'h0;
            end else if (low_cnt_reg < `URC_IR_MIN_LOW) begin
                low_cnt_next = 2'(low_cnt_reg + 1'b1);
                pulse_next   = (2'(low_cnt_reg + 1'b1) == `URC_IR_MIN_LOW);
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_cnt_reg <= '0;
            low_cnt_reg <= 2'h0;
            pulse_reg   <= 1'b0;
        end else begin
            div_cnt_reg <= div_cnt_next;
            low_cnt_reg <= low_cnt_next;
            pulse_reg   <= pulse_next;
        end
    end

    assign pulse_out = pulse_reg;

endmodule
`default_nettype wire

//--- hdl/urc_pkg.sv
// types of the channel control block
// assumes urc_regs.svh holds the numbers
package urc_pkg;

    typedef struct packed {
        logic       rx_error_irq_enable;
        logic       rx_full_irq_enable;
        logic       tx_empty_irq_enable;
        logic       rx_full_threshold_sel;
        logic       channel_transfer_enable;
    } urc_ctl_t;

    typedef struct packed {
        logic [2:0] ir_detect_clock_divider;
        logic       infrared_mode_on;
    } urc_exp_t;

    // bit order matches the status and mask registers
    typedef struct packed {
        logic       tx_empty;
        logic       rx_full;
        logic       rx_error;
    } urc_evt_t;

endpackage

//--- hdl/urc_regs.svh
// offsets, field positions, reset values and timing counts
// assumes an 8-bit register port at byte offsets
// Function
// - receive error requests when enabled; enable resets off
// - buffer full requests at threshold; enable resets off
// - transmit empty requests as each byte enters the shifter
// - threshold select: 0 first byte, 1 second byte
// - transfers only while channel enable is one; resets off
// - writing zero to channel enable flushes the transmit buffer
// - three-bit field divides the clock by two to the n
// - low pulse valid only if two detection clocks long
// - infrared mode shapes pulses; off is a plain port
// - second-byte flag sets on second load, clears on first read
`ifndef URC_REGS_SVH
`define URC_REGS_SVH

// ------------------------------------------------------------------
// addresses
// ------------------------------------------------------------------
`define URC_CH0_CTL_ADDR     16'h4104
`define URC_CH0_EXP_ADDR     16'h4105
`define URC_CH1_CTL_ADDR     16'h4124
`define URC_CH1_EXP_ADDR     16'h4125
// offsets from the channel control address
`define URC_EXP_OFS          16'h0001
`define URC_STAT_OFS         16'h0008
`define URC_MASK_OFS         16'h0009
`define URC_FLAG_OFS         16'h000A

// ------------------------------------------------------------------
// field positions
// ------------------------------------------------------------------
`define URC_CTL_ERR_BIT      6
`define URC_CTL_FULL_BIT     5
`define URC_CTL_EMPTY_BIT    4
`define URC_CTL_THR_BIT      1
`define URC_CTL_EN_BIT       0
`define URC_EXP_DIV_LSB      4
`define URC_EXP_DIV_MSB      6
`define URC_EXP_IR_BIT       0
`define URC_EVT_ERR_BIT      0
`define URC_EVT_FULL_BIT     1
`define URC_EVT_EMPTY_BIT    2
`define URC_FLAG_RDY_BIT     0
`define URC_FLAG_BUSY_BIT    1
`define URC_FLAG_2ND_BIT     2

// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define URC_CTL_RESET        8'h00
`define URC_EXP_RESET        8'h00
`define URC_STAT_RESET       3'h0
`define URC_MASK_RESET       3'h0

// ------------------------------------------------------------------
// timing, in oversample ticks or detection clock cycles; receive buffer depth in bytes
// ------------------------------------------------------------------
`define URC_IR_MIN_LOW       2'h2
`define URC_IR_TX_PULSE      2'h3
`define URC_IR_RX_STRETCH    5'h10
`define URC_RX_BUF_DEPTH     2'h2

`endif

//--- hdl/urc_top.sv
// one uart channel: control, expansion, interrupts, infrared shaping
// assumes framing and buffers elsewhere report by one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
`include "urc_regs.svh"

module urc_top
    import urc_pkg::*;
#(
    parameter logic [15:0] CHAN_BASE = `URC_CH0_CTL_ADDR
) (
    input  wire logic        sys_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic [15:0] addr_in,
    input  wire logic [7:0]  wr_data_in,
    input  wire logic        wr_en_in,
    input  wire logic        rd_en_in,
    output logic      [7:0]  rd_data_out,
    input  wire logic        rx_error_in,
    input  wire logic        rx_byte_load_in,
    input  wire logic        rx_byte_read_in,
    input  wire logic        tx_buf_to_shift_in,
    input  wire logic        tx_shifter_busy_flag_in,
    input  wire logic        ovs_tick_in,
    input  wire logic        tx_bit_start_in,
    input  wire logic        tx_serial_in,
    input  wire logic        sin_pin_in,
    output logic             sout_pin_out,
    output logic             rx_serial_out,
    output logic             channel_transfer_enable_out,
    output logic             tx_buffer_flush_out,
    output logic             rx_data_ready_flag_out,
    output logic             rx_second_byte_flag_out,
    output logic             irq_rx_error_out,
    output logic             irq_rx_full_out,
    output logic             irq_tx_empty_out,
    output logic             irq_out
);

    urc_ctl_t    ctl_reg;
    urc_ctl_t    ctl_next;
    urc_exp_t    exp_reg;
    urc_exp_t    exp_next;
    urc_evt_t    stat_reg;
    urc_evt_t    stat_next;
    urc_evt_t    mask_reg;
    urc_evt_t    mask_next;
    urc_evt_t    evt;
    logic [1:0]  rx_cnt_reg;
    logic [1:0]  rx_cnt_next;
    logic [7:0]  rd_data_reg;
    logic [7:0]  rd_data_next;
    logic        flush_reg;
    logic        flush_next;
    logic [2:0]  irq_lines_reg;
    logic [2:0]  irq_lines_next;
    logic        irq_reg;
    logic        irq_next;
    logic [1:0]  tx_pulse_reg;
    logic [1:0]  tx_pulse_next;
    logic [4:0]  rx_stretch_reg;
    logic [4:0]  rx_stretch_next;
    logic        sout_reg;
    logic        sout_next;
    logic        rxs_reg;
    logic        rxs_next;
    logic        sin_meta_reg;
    logic        sin_sync_reg;
    logic        ir_pulse;
    logic        ir_active;
    logic        sel_ctl;
    logic        sel_exp;
    logic        sel_stat;
    logic        sel_mask;
    logic        sel_flag;
    logic        rx_load_ok;
    logic        rx_read_ok;
    logic        rdy_reg;
    logic        rdy_next;
    logic        sec_reg;
    logic        sec_next;

    localparam logic [7:0] CTL_RST = `URC_CTL_RESET;
    localparam logic [7:0] EXP_RST = `URC_EXP_RESET;

    function automatic logic addr_hit(input logic [15:0] a,
                                      input logic [15:0] ofs);
        addr_hit = (a == 16'(CHAN_BASE + ofs));
    endfunction

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    always_comb begin
        sel_ctl  = addr_hit(addr_in, 16'h0000);
        sel_exp  = addr_hit(addr_in, `URC_EXP_OFS);
        sel_stat = addr_hit(addr_in, `URC_STAT_OFS);
        sel_mask = addr_hit(addr_in, `URC_MASK_OFS);
        sel_flag = addr_hit(addr_in, `URC_FLAG_OFS);
    end

    // ------------------------------------------------------------------
    // control and expansion registers
    // ------------------------------------------------------------------
    always_comb begin
        ctl_next   = ctl_reg;
        exp_next   = exp_reg;
        mask_next  = mask_reg;
        flush_next = 1'b0;
        if (wr_en_in && sel_ctl) begin
            ctl_next.rx_error_irq_enable     = wr_data_in[`URC_CTL_ERR_BIT];
            ctl_next.rx_full_irq_enable      = wr_data_in[`URC_CTL_FULL_BIT];
            ctl_next.tx_empty_irq_enable     = wr_data_in[`URC_CTL_EMPTY_BIT];
            ctl_next.rx_full_threshold_sel   = wr_data_in[`URC_CTL_THR_BIT];
            ctl_next.channel_transfer_enable = wr_data_in[`URC_CTL_EN_BIT];
            // any write of zero flushes, even if already disabled
            flush_next = !wr_data_in[`URC_CTL_EN_BIT];
        end
        if (wr_en_in && sel_exp) begin
            exp_next.ir_detect_clock_divider =
                wr_data_in[`URC_EXP_DIV_MSB:`URC_EXP_DIV_LSB];
            exp_next.infrared_mode_on = wr_data_in[`URC_EXP_IR_BIT];
        end
        if (wr_en_in && sel_mask) begin
            mask_next = urc_evt_t'(wr_data_in[2:0]);
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctl_reg   <= urc_ctl_t'({CTL_RST[6:4], CTL_RST[1:0]});
            exp_reg   <= urc_exp_t'({EXP_RST[6:4], EXP_RST[0]});
            mask_reg  <= urc_evt_t'(`URC_MASK_RESET);
            flush_reg <= 1'b0;
        end else begin
            ctl_reg   <= ctl_next;
            exp_reg   <= exp_next;
            mask_reg  <= mask_next;
            flush_reg <= flush_next;
        end
    end

    // ------------------------------------------------------------------
    // receive buffer count and its flags
    // ------------------------------------------------------------------
    // loads into a full buffer are the overrun case, handled upstream
    always_comb begin
        rx_load_ok  = rx_byte_load_in && ctl_reg.channel_transfer_enable
                      && (rx_cnt_reg < `URC_RX_BUF_DEPTH);
        rx_read_ok  = rx_byte_read_in && (rx_cnt_reg != 2'h0);
        rx_cnt_next = rx_cnt_reg;
        if (rx_load_ok && !rx_read_ok) begin
            rx_cnt_next = 2'(rx_cnt_reg + 1'b1);
        end else if (rx_read_ok && !rx_load_ok) begin
            rx_cnt_next = 2'(rx_cnt_reg - 1'b1);
        end
        rdy_next = (rx_cnt_next != 2'h0);
        sec_next = (rx_cnt_next == 2'h2);
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rx_cnt_reg <= 2'h0;
            rdy_reg    <= 1'b0;
            sec_reg    <= 1'b0;
        end else begin
            rx_cnt_reg <= rx_cnt_next;
            rdy_reg    <= rdy_next;
            sec_reg    <= sec_next;
        end
    end

    // ------------------------------------------------------------------
    // events, sticky status and request lines
    // ------------------------------------------------------------------
    always_comb begin
        evt.rx_error = rx_error_in && ctl_reg.channel_transfer_enable;
        // threshold 0: first byte, as ready sets; 1: second byte
        evt.rx_full  = rx_load_ok &&
                       (ctl_reg.rx_full_threshold_sel ?
                        (rx_cnt_next == 2'h2) : (rx_cnt_next != 2'h0));
        evt.tx_empty = tx_buf_to_shift_in
                       && ctl_reg.channel_transfer_enable;
        stat_next = stat_reg;
        if (wr_en_in && sel_stat) begin
            stat_next = urc_evt_t'(stat_reg & ~urc_evt_t'(wr_data_in[2:0]));
        end
        // a new event wins over a clear in the same cycle
        stat_next = urc_evt_t'(stat_next | evt);
        irq_lines_next[`URC_EVT_ERR_BIT] = stat_next.rx_error
            && ctl_next.rx_error_irq_enable;
        irq_lines_next[`URC_EVT_FULL_BIT] = stat_next.rx_full
            && ctl_next.rx_full_irq_enable;
        irq_lines_next[`URC_EVT_EMPTY_BIT] = stat_next.tx_empty
            && ctl_next.tx_empty_irq_enable;
        irq_next = |(irq_lines_next & mask_next);
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stat_reg      <= urc_evt_t'(`URC_STAT_RESET);
            irq_lines_reg <= 3'h0;
            irq_reg       <= 1'b0;
        end else begin
            stat_reg      <= stat_next;
            irq_lines_reg <= irq_lines_next;
            irq_reg       <= irq_next;
        end
    end

    // ------------------------------------------------------------------
    // read data, one cycle after the strobe
    // ------------------------------------------------------------------
    always_comb begin
        rd_data_next = 8'h00;
        if (rd_en_in) begin
            if (sel_ctl) begin
                rd_data_next[`URC_CTL_ERR_BIT]   = ctl_reg.rx_error_irq_enable;
                rd_data_next[`URC_CTL_FULL_BIT]  = ctl_reg.rx_full_irq_enable;
                rd_data_next[`URC_CTL_EMPTY_BIT] = ctl_reg.tx_empty_irq_enable;
                rd_data_next[`URC_CTL_THR_BIT]   = ctl_reg.rx_full_threshold_sel;
                rd_data_next[`URC_CTL_EN_BIT]  = ctl_reg.channel_transfer_enable;
            end else if (sel_exp) begin
                rd_data_next[`URC_EXP_DIV_MSB:`URC_EXP_DIV_LSB] =
                    exp_reg.ir_detect_clock_divider;
                rd_data_next[`URC_EXP_IR_BIT] = exp_reg.infrared_mode_on;
            end else if (sel_stat) begin
                rd_data_next[2:0] = stat_reg;
            end else if (sel_mask) begin
                rd_data_next[2:0] = mask_reg;
            end else if (sel_flag) begin
                rd_data_next[`URC_FLAG_RDY_BIT]  = rdy_reg;
                rd_data_next[`URC_FLAG_BUSY_BIT] = tx_shifter_busy_flag_in;
                rd_data_next[`URC_FLAG_2ND_BIT]  = sec_reg;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_data_reg <= 8'h00;
        end else begin
            rd_data_reg <= rd_data_next;
        end
    end

    // ------------------------------------------------------------------
    // input pin synchroniser
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sin_meta_reg <= 1'b1;
            sin_sync_reg <= 1'b1;
        end else begin
            sin_meta_reg <= sin_pin_in;
            sin_sync_reg <= sin_meta_reg;
        end
    end

    assign ir_active = exp_reg.infrared_mode_on
                       && ctl_reg.channel_transfer_enable;

    urc_ir_demod #(
        .DIV_W      (7)
    ) u_demod (
        .sys_clk_in (sys_clk_in),
        .rst_n_in   (rst_n_in),
        .enable_in  (ir_active),
        .line_in    (sin_sync_reg),
        .div_sel_in (exp_reg.ir_detect_clock_divider),
        .pulse_out  (ir_pulse)
    );

    // ------------------------------------------------------------------
    // line shaping: infrared pulses or plain serial
    // ------------------------------------------------------------------
    // tx zero bit: short low pulse; rx pulse: stretched to a bit of low
    always_comb begin
        tx_pulse_next   = tx_pulse_reg;
        rx_stretch_next = rx_stretch_reg;
        if (!ir_active) begin
            tx_pulse_next   = 2'h0;
            rx_stretch_next = 5'h00;
        end else begin
            if (tx_bit_start_in && !tx_serial_in) begin
                tx_pulse_next = `URC_IR_TX_PULSE;
            end else if (ovs_tick_in && tx_pulse_reg != 2'h0) begin
                tx_pulse_next = 2'(tx_pulse_reg - 1'b1);
            end
            if (ir_pulse) begin
                rx_stretch_next = `URC_IR_RX_STRETCH;
            end else if (ovs_tick_in && rx_stretch_reg != 5'h00) begin
                rx_stretch_next = 5'(rx_stretch_reg - 1'b1);
            end
        end
        if (!ctl_reg.channel_transfer_enable) begin
            sout_next = 1'b1;
            rxs_next  = 1'b1;
        end else if (exp_reg.infrared_mode_on) begin
            sout_next = (tx_pulse_next == 2'h0);
            rxs_next  = (rx_stretch_next == 5'h00);
        end else begin
            sout_next = tx_serial_in;
            rxs_next  = sin_sync_reg;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tx_pulse_reg   <= 2'h0;
            rx_stretch_reg <= 5'h00;
            sout_reg       <= 1'b1;
            rxs_reg        <= 1'b1;
        end else begin
            tx_pulse_reg   <= tx_pulse_next;
            rx_stretch_reg <= rx_stretch_next;
            sout_reg       <= sout_next;
            rxs_reg        <= rxs_next;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign rd_data_out                 = rd_data_reg;
    assign sout_pin_out                = sout_reg;
    assign rx_serial_out               = rxs_reg;
    assign channel_transfer_enable_out = ctl_reg.channel_transfer_enable;
    assign tx_buffer_flush_out         = flush_reg;
    assign rx_data_ready_flag_out      = rdy_reg;
    assign rx_second_byte_flag_out     = sec_reg;
    assign irq_rx_error_out            = irq_lines_reg[`URC_EVT_ERR_BIT];
    assign irq_rx_full_out             = irq_lines_reg[`URC_EVT_FULL_BIT];
    assign irq_tx_empty_out            = irq_lines_reg[`URC_EVT_EMPTY_BIT];
    assign irq_out                     = irq_reg;

endmodule
`default_nettype wire

//--- test/testbench.sv
// self-checking bench for the channel block
// assumes channel 0 and the remote line model
`timescale 1ns/1ps
`default_nettype none
`include "urc_regs.svh"

module testbench;
    localparam logic [15:0] CTL = `URC_CH0_CTL_ADDR;
    localparam logic [15:0] EXP = CTL + `URC_EXP_OFS;
    localparam logic [15:0] STA = CTL + `URC_STAT_OFS;
    localparam logic [15:0] MSK = CTL + `URC_MASK_OFS;
    localparam logic [15:0] FLG = CTL + `URC_FLAG_OFS;
    logic        clk = 0, rst_n = 0, we = 0, re = 0, busy = 0, ovs = 0;
    logic        tbs = 0, txs = 1, go = 0;
    logic [15:0] addr = '0;
    logic [7:0]  wdat = '0, wid = '0, rdat;
    logic [3:0]  ev = '0;
    logic [1:0]  oc = '0;
    logic        sin, sout, rxs, en, fl, rdy, sec, ie, ifl, it, irq;
    int          fail_count = 0, total_checks = 0;
    wire  [7:0]  iv = {4'h0, irq, ie, ifl, it};

    always #5 clk = ~clk;
    // oversample tick every fourth cycle
    always @(posedge clk) begin
        oc  <= oc + 2'h1;
        ovs <= (oc == 2'h3);
    end

    urc_top urc_top_inst (
        .sys_clk_in(clk), .rst_n_in(rst_n), .addr_in(addr), .wr_data_in(wdat),
        .wr_en_in(we), .rd_en_in(re), .rd_data_out(rdat),
        .rx_error_in(ev[0]), .rx_byte_load_in(ev[1]), .rx_byte_read_in(ev[2]),
        .tx_buf_to_shift_in(ev[3]), .tx_shifter_busy_flag_in(busy),
        .ovs_tick_in(ovs), .tx_bit_start_in(tbs), .tx_serial_in(txs),
        .sin_pin_in(sin), .sout_pin_out(sout), .rx_serial_out(rxs),
        .channel_transfer_enable_out(en), .tx_buffer_flush_out(fl),
        .rx_data_ready_flag_out(rdy), .rx_second_byte_flag_out(sec),
        .irq_rx_error_out(ie), .irq_rx_full_out(ifl),
        .irq_tx_empty_out(it), .irq_out(irq));
    urc_remote_line urc_remote_line_inst (.clk_in(clk), .rst_n_in(rst_n),
        .start_in(go), .width_in(wid), .line_out(sin));

    // ----------------------------------------------------------------
    // bus and event helpers
    // ----------------------------------------------------------------
    task automatic chk(string what, logic [7:0] e, logic [7:0] got);
        total_checks++;
        if (got !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, e, got);
        end
    endtask
    task automatic wr(logic [15:0] a, logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdat <= d;
        we   <= 1'b1;
        @(posedge clk);
        we   <= 1'b0;
        #1;
    endtask
    task automatic rd(logic [15:0] a, logic [7:0] e);
        @(posedge clk);
        addr <= a;
        re   <= 1'b1;
        @(posedge clk);
        re   <= 1'b0;
        #1 chk("read data", e, rdat);
    endtask
    task automatic pulse(logic [3:0] v);
        @(posedge clk);
        ev <= v;
        @(posedge clk);
        ev <= 4'h0;
        #1;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_map();
        rd(CTL, `URC_CTL_RESET);
        rd(EXP, `URC_EXP_RESET);
        wr(CTL, 8'hFF);
        rd(CTL, 8'h73);
        wr(EXP, 8'hFF);
        rd(EXP, 8'h71);
        wr(16'h4106, 8'hFF);
        rd(16'h4106, 8'h00);
        wr(CTL, 8'h00);
        wr(EXP, 8'h00);
        $display("map test done");
    endtask
    task automatic t_irq();
        wr(CTL, 8'h41);
        wr(MSK, 8'h07);
        pulse(4'h1);
        chk("irqs", 8'h0C, iv);
        rd(STA, 8'h01);
        wr(MSK, 8'h00);
        @(posedge clk);
        #1 chk("masked irqs", 8'h04, iv);
        wr(STA, 8'h01);
        @(posedge clk);
        #1 chk("cleared irqs", 8'h00, iv);
        wr(CTL, 8'h01);
        pulse(4'h1);
        chk("gated irqs", 8'h00, iv);
        wr(STA, 8'h07);
        $display("interrupt test done");
    endtask
    task automatic t_thr();
        for (int t = 0; t < 2; t++) begin
            wr(CTL, t ? 8'h23 : 8'h21);
            pulse(4'h2);
            chk("one byte", t ? 8'h01 : 8'h03, {5'h0, sec, ifl, rdy});
            pulse(4'h2);
            chk("two bytes", 8'h07, {5'h0, sec, ifl, rdy});
            rd(FLG, 8'h05);
            pulse(4'h4);
            chk("one read", 8'h03, {5'h0, sec, ifl, rdy});
            pulse(4'h4);
            wr(STA, 8'h07);
        end
        $display("threshold test done");
    endtask
    task automatic t_tx();
        wr(CTL, 8'h11);
        pulse(4'h8);
        chk("empty irq", 8'h01, {7'h00, it});
        @(posedge clk) busy <= 1'b1;
        rd(FLG, 8'h02);
        @(posedge clk) busy <= 1'b0;
        rd(FLG, 8'h00);
        wr(CTL, 8'h00);
        chk("flush", 8'h01, {6'h00, en, fl});
        wr(STA, 8'h07);
        pulse(4'hB);
        rd(STA, 8'h00);
        chk("idle flags", 8'h00, {6'h00, sec, rdy});
        $display("transmit test done");
    endtask
    task automatic t_ir();
        // dividers stay faster than the oversample tick
        logic [2:0] dv[4] = '{3'h0, 3'h0, 3'h1, 3'h1};
        logic [7:0] wd[4] = '{8'h01, 8'h02, 8'h02, 8'h06};
        logic       xl[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
        logic       low;
        wr(CTL, 8'h01);
        for (int i = 0; i < 4; i++) begin
            wr(EXP, {1'b0, dv[i], 4'h1});
            @(posedge clk);
            go  <= 1'b1;
            wid <= wd[i];
            @(posedge clk);
            go  <= 1'b0;
            low = 1'b0;
            for (int c = 0; c < 40; c++) begin
                @(negedge clk);
                if (rxs === 1'b0) low = 1'b1;
            end
            chk("ir accept", {7'h00, xl[i]}, {7'h00, low});
            repeat (80) @(posedge clk);
        end
        @(posedge clk);
        tbs <= 1'b1;
        txs <= 1'b0;
        @(posedge clk);
        tbs <= 1'b0;
        @(posedge clk);
        #1 chk("ir tx low", 8'h00, {7'h00, sout});
        wr(EXP, 8'h00);
        repeat (16) @(posedge clk);
        #1 chk("plain tx", 8'h00, {7'h00, sout});
        $display("infrared test done");
    endtask

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_map();
        t_irq();
        t_thr();
        t_tx();
        t_ir();
        wrap_up();
    end
endmodule

`default_nettype wire

//--- test/urc_checker.sv
// concurrent checks on the channel block ports
// assumes one clock and async low reset
`timescale 1ns/1ps
`default_nettype none

module urc_checker #(
    parameter logic [15:0] CHAN_BASE = 16'h4104
) (
    input wire logic        sys_clk_in,
    input wire logic        rst_n_in,
    input wire logic [15:0] addr_in,
    input wire logic [7:0]  wr_data_in,
    input wire logic        wr_en_in,
    input wire logic        rd_en_in,
    input wire logic [7:0]  rd_data_out,
    input wire logic        rx_error_in,
    input wire logic        rx_byte_load_in,
    input wire logic        rx_byte_read_in,
    input wire logic        tx_buf_to_shift_in,
    input wire logic        channel_transfer_enable_out,
    input wire logic        tx_buffer_flush_out,
    input wire logic        rx_data_ready_flag_out,
    input wire logic        rx_second_byte_flag_out,
    input wire logic        irq_rx_error_out,
    input wire logic        irq_rx_full_out,
    input wire logic        irq_tx_empty_out,
    input wire logic        irq_out
);
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_n_in);
    logic flush_req;
    assign flush_req = wr_en_in && addr_in == CHAN_BASE && !wr_data_in[0];

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    a_error_irq_cause: assert property (
        $rose(irq_rx_error_out) |-> $past(rx_error_in))
        else $error("error irq without cause");
    a_full_irq_cause: assert property (
        $rose(irq_rx_full_out) |-> $past(rx_byte_load_in))
        else $error("full irq without load");
    a_empty_irq_cause: assert property (
        $rose(irq_tx_empty_out) |-> $past(tx_buf_to_shift_in))
        else $error("empty irq without move");
    a_irq_has_source: assert property (
        irq_out |-> irq_rx_error_out || irq_rx_full_out || irq_tx_empty_out)
        else $error("irq without source");
    a_load_sets_ready: assert property (
        rx_byte_load_in && channel_transfer_enable_out |=> rx_data_ready_flag_out)
        else $error("ready missing after load");
    a_second_clears: assert property (
        rx_byte_read_in && !rx_byte_load_in && rx_second_byte_flag_out
        |=> !rx_second_byte_flag_out && rx_data_ready_flag_out)
        else $error("second flag wrong after read");
    a_flush_on_disable: assert property (
        tx_buffer_flush_out == $past(flush_req))
        else $error("flush not after disabling write");
    a_read_data_idle: assert property (
        !$past(rd_en_in) |-> rd_data_out == 8'h00)
        else $error("read data outside answer");

    c_error_irq: cover property (rx_error_in ##1 irq_out);
    c_two_bytes: cover property ($rose(rx_second_byte_flag_out));
    c_flush: cover property (tx_buffer_flush_out);
endmodule

bind urc_top urc_checker #(.CHAN_BASE(CHAN_BASE)) urc_checker_inst (.*);

`default_nettype wire

//--- test/urc_remote_line.sv
// far-side infrared emitter model
// assumes one low pulse per start, same clock
`timescale 1ns/1ps
`default_nettype none

module urc_remote_line (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       start_in,
    input  wire logic [7:0] width_in,
    output logic            line_out
);
    logic [7:0] left_reg;

    // line idles high
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            left_reg <= 8'h00;
        end else if (start_in) begin
            left_reg <= width_in;
        end else if (left_reg != 8'h00) begin
            left_reg <= left_reg - 8'h01;
        end
    end
    assign line_out = (left_reg == 8'h00);
endmodule

`default_nettype wire
